// ===== src/sleep_wake_mode_controller.sv
//Contract
// R1 - sleep entered only by host configuration write
// R2 - sleep turns off all but wake detectors
// R3 - bus wake: fall, long dominant, then rise
// R4 - bus wake enters low-power, transceiver stays off
// R5 - wake from sleep pulls interrupt low
// R6 - wake source latched; bus wake reads 11
// R7 - host enables transceiver only after reset release
// R8 - ignition wake needs high past debounce time
// R9 - regulator first, then startup timer holds reset
// R10 - spi ready exactly at reset rising edge
// R11 - ignition wake needs no edge; reads 10 (code wakes only after the debounced level was low first)
// R12 - bus receiver on only for monitor window
// R13 - re-arm after bus high a few microseconds
// R14 - low-power only regulator on, select high
// R15 - select low leaves lowest-current condition
// R16 - low-power bus or ignition wake interrupts host
// R17 - host reads source bits, enables watchdog itself
// R18 - switch interrupt needs both enable bits
// R19 - source off keeps low-power condition
// R20 - power-up active, watchdog on unless strap high
// R21 - no spi during reset delay
// R22 - undervoltage interrupts, inhibits, keeps configuration
// R23 - undervoltage in sleep ignored above minimum
// R24 - 16-bit msb-first frame, config in, status out
// R25 - host closes after sixteen clocks, then waits
// R26 - config changes show in next status word
// R27 - analog inputs synchronised, timers cycle counted
// R28 - interrupt low until host reads status
`timescale 1ns/1ps
module sleep_wake_mode_controller #(
	parameter int unsigned STARTUP_DELAY_CYC = mode_ctrl_pkg::STARTUP_DELAY_CYC,
	parameter int unsigned MONITOR_CYC = mode_ctrl_pkg::MONITOR_CYC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// supply comparators
	input wire logic supply_low_in,
	input wire logic supply_ok_in,
	input wire logic supply_min_in,
	input wire logic vcc_valid_in,
	// wake sources
	input wire logic bus_low_in,
	input wire logic bus_high_in,
	input wire logic ignition_input_in,
	// switch interface
	input wire logic [mode_ctrl_pkg::NUM_SW-1:0] pulse_control_input_in,
	input wire logic [mode_ctrl_pkg::NUM_SW-1:0] switch_state_in,
	// strap sampled during reset
	input wire logic divider_strap_in,
	// spi pins
	input wire logic spi_select_n_in,
	input wire logic spi_sck_in,
	input wire logic spi_mosi_in,
	output logic spi_miso_out,
	output logic spi_miso_oe_out,
	// host lines
	output logic wake_irq_n_out,
	output logic host_reset_out_n_out,
	// function enables and mode
	output logic regulator_on_out,
	output logic transceiver_on_out,
	output logic termination_on_out,
	output logic watchdog_on_out,
	output logic divider_on_out,
	output logic switch_unit_on_out,
	output logic bus_receiver_on_out,
	output logic low_current_out,
	output logic [1:0] mode_out
);
	import mode_ctrl_pkg::*;

	localparam int unsigned SYNC_W = 9 + 2 * NUM_SW;

	frame_if frm ();

	logic [SYNC_W-1:0] sync_m_ff, sync_s_ff;
	logic uv_s, ok_s, min_s, vcc_s, bus_low_s, bus_high_s, ign_s, strap_s, sel_s;
	logic [NUM_SW-1:0] pwm_s, sw_s, pwm_d_ff;

	// debounce and switch group
	logic [TMR_W-1:0] ign_cnt_ff, nxt_ign_cnt;
	logic ign_deb_ff, nxt_ign_deb, ign_rise_ff, nxt_ign_rise;
	logic [NUM_SW-1:0] sw_latch_ff, nxt_sw_latch;
	logic sw_evt_ff, nxt_sw_evt;

	// mode group
	pwr_state_t state_ff, nxt_state;
	logic [TMR_W-1:0] timer_ff, nxt_timer;
	logic [15:0] cfg_ff, nxt_cfg;
	logic [1:0] src_ff, nxt_src;
	logic irq_n_ff, nxt_irq_n, uv_ff, nxt_uv;
	logic reset_n_ff, nxt_reset_n, reg_ff, nxt_reg, xcvr_ff, nxt_xcvr;
	logic term_ff, nxt_term, wd_ff, nxt_wd, div_ff, nxt_div;
	logic swu_ff, nxt_swu, lowc_ff, nxt_lowc;

	logic bus_wake, det_enable;
	logic [NUM_SW-1:0] cs_on;
	logic [15:0] status_word;

	// every pin level passes two flops before use
	always_ff @(posedge clk_in) begin // [R27]
		if (rst_in) begin
			sync_m_ff <= '0;
			sync_s_ff <= '0;
			pwm_d_ff <= '0;
		end else begin
			sync_m_ff <= {supply_low_in, supply_ok_in, supply_min_in, vcc_valid_in, bus_low_in,
				bus_high_in, ignition_input_in, divider_strap_in, pulse_control_input_in,
				switch_state_in, spi_select_n_in};
			sync_s_ff <= sync_m_ff;
			pwm_d_ff <= pwm_s;
		end
	end

	assign {uv_s, ok_s, min_s, vcc_s, bus_low_s, bus_high_s, ign_s, strap_s, pwm_s, sw_s, sel_s} =
		sync_s_ff;

	spi_frame_slave u_spi (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.sel_n_in(spi_select_n_in),
		.sck_in(spi_sck_in),
		.mosi_in(spi_mosi_in),
		.miso_out(spi_miso_out),
		.miso_oe_out(spi_miso_oe_out),
		.frm(frm.spi)
	);

	assign det_enable = (state_ff == ST_SLEEP) ||
		(state_ff == ST_ACTIVE && !cfg_ff[CFG_LIN]); // [R16]

	bus_wake_detector #(
		.MONITOR_CYC(MONITOR_CYC)
	) u_det (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.enable_in(det_enable),
		.bus_low_in(bus_low_s),
		.bus_high_in(bus_high_s),
		.wake_out(bus_wake),
		.receiver_on_out(bus_receiver_on_out)
	);

	// current source active when enabled and driven on directly or by its pulse input
	assign cs_on = cfg_ff[CFG_CSE_LSB +: NUM_SW] & (cfg_ff[CFG_CSC_LSB +: NUM_SW] | pwm_s); // [R19]

	always_comb begin
		nxt_ign_cnt = '0;
		nxt_ign_deb = ign_deb_ff;
		nxt_ign_rise = 1'b0;
		if (ign_s != ign_deb_ff) begin
			nxt_ign_cnt = ign_cnt_ff + 1'b1;
			// both edges debounced, so a new wake needs a long low first
			if (ign_cnt_ff >= TMR_W'(IGN_DEBOUNCE_CYC - 1)) begin // [R8]
				nxt_ign_deb = ign_s;
				nxt_ign_rise = ign_s; // [R11]
				nxt_ign_cnt = '0;
			end
		end
		// switch state updates on the falling edge of its pulse input
		nxt_sw_latch = sw_latch_ff;
		for (int i = 0; i < NUM_SW; i++) begin
			if (pwm_d_ff[i] && !pwm_s[i]) begin
				nxt_sw_latch[i] = sw_s[i];
			end
		end
		nxt_sw_evt = (state_ff == ST_ACTIVE) && |((nxt_sw_latch ^ sw_latch_ff) &
			cfg_ff[CFG_CSE_LSB +: NUM_SW] & cfg_ff[CFG_CSIE_LSB +: NUM_SW]); // [R18]
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ign_cnt_ff <= '0;
			ign_deb_ff <= 1'b0;
			ign_rise_ff <= 1'b0;
			sw_latch_ff <= '0;
			sw_evt_ff <= 1'b0;
		end else begin
			ign_cnt_ff <= nxt_ign_cnt;
			ign_deb_ff <= nxt_ign_deb;
			ign_rise_ff <= nxt_ign_rise;
			sw_latch_ff <= nxt_sw_latch;
			sw_evt_ff <= nxt_sw_evt;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_timer = timer_ff;
		nxt_cfg = cfg_ff;
		nxt_src = src_ff;
		nxt_irq_n = irq_n_ff;
		nxt_uv = uv_ff;
		case (state_ff)
			ST_SLEEP: begin
				// undervoltage alone is ignored here; only loss of supply restarts
				if (min_s) begin // [R23]
					nxt_state = ST_RAMP;
				end else if (bus_wake || ign_rise_ff) begin // [R2]
					nxt_state = ST_RAMP; // [R9]
					nxt_src = bus_wake ? SRC_BUS : SRC_IGN; // [R6] [R11]
					nxt_irq_n = 1'b0; // [R5]
					nxt_cfg[CFG_SLEEP] = 1'b0;
					nxt_cfg[CFG_LIN] = 1'b0; // [R4]
				end
			end
			ST_RAMP: begin
				nxt_timer = '0;
				if (vcc_s) begin // [R9]
					nxt_state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				nxt_timer = timer_ff + 1'b1;
				if (timer_ff >= TMR_W'(STARTUP_DELAY_CYC - 1)) begin // [R21]
					nxt_state = ST_ACTIVE; // [R10]
					nxt_cfg[CFG_WDD] = strap_s; // [R20]
					nxt_timer = '0;
				end
			end
			ST_ACTIVE: begin
				if (frm.frame_load) begin
					nxt_cfg = frm.rx_word; // [R24] [R26]
					nxt_irq_n = 1'b1; // [R28]
					nxt_src = SRC_NONE;
					if (frm.rx_word[CFG_SLEEP]) begin // [R1]
						nxt_state = ST_SLEEP;
					end
				end
				if (nxt_state == ST_ACTIVE) begin
					// events come after the clear so a coincident event is kept
					if (ok_s) begin // [R22]
						nxt_uv = 1'b0;
					end
					if (uv_s && !uv_ff) begin // [R22]
						nxt_uv = 1'b1;
						nxt_irq_n = 1'b0;
					end
					if (sw_evt_ff) begin // [R18]
						nxt_src = SRC_SWITCH;
						nxt_irq_n = 1'b0;
					end
					if (ign_rise_ff) begin // [R16]
						nxt_src = SRC_IGN;
						nxt_irq_n = 1'b0;
					end
					if (bus_wake) begin // [R16]
						nxt_src = SRC_BUS;
						nxt_irq_n = 1'b0;
					end
				end else begin
					nxt_uv = 1'b0;
				end
			end
			default: begin
				nxt_state = ST_RAMP;
			end
		endcase
	end

	// enables follow the next state so reset release and spi readiness share an edge
	always_comb begin
		nxt_reg = (nxt_state != ST_SLEEP); // [R2]
		nxt_reset_n = (nxt_state == ST_ACTIVE); // [R10]
		nxt_term = (nxt_state != ST_SLEEP); // [R4]
		nxt_xcvr = (nxt_state == ST_ACTIVE) && nxt_cfg[CFG_LIN] && !nxt_uv; // [R22]
		nxt_wd = (nxt_state == ST_ACTIVE) && !nxt_cfg[CFG_WDD];
		nxt_div = (nxt_state == ST_ACTIVE) && nxt_cfg[CFG_DIV];
		nxt_swu = (nxt_state == ST_ACTIVE) && |cs_on && !nxt_uv; // [R22]
		nxt_lowc = (nxt_state == ST_ACTIVE) && !nxt_cfg[CFG_LIN] && nxt_cfg[CFG_WDD] &&
			!nxt_cfg[CFG_DIV] && sel_s && !(|cs_on); // [R14] [R15] [R19]
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_ff <= ST_RAMP;
			timer_ff <= '0;
			cfg_ff <= CFG_RESET;
			src_ff <= SRC_NONE;
			irq_n_ff <= 1'b1;
			uv_ff <= 1'b0;
			reset_n_ff <= 1'b0;
			reg_ff <= 1'b1;
			term_ff <= 1'b1;
			xcvr_ff <= 1'b0;
			wd_ff <= 1'b0;
			div_ff <= 1'b0;
			swu_ff <= 1'b0;
			lowc_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			timer_ff <= nxt_timer;
			cfg_ff <= nxt_cfg;
			src_ff <= nxt_src;
			irq_n_ff <= nxt_irq_n;
			uv_ff <= nxt_uv;
			reset_n_ff <= nxt_reset_n;
			reg_ff <= nxt_reg;
			term_ff <= nxt_term;
			xcvr_ff <= nxt_xcvr;
			wd_ff <= nxt_wd;
			div_ff <= nxt_div;
			swu_ff <= nxt_swu;
			lowc_ff <= nxt_lowc;
		end
	end

	always_comb begin
		status_word = 16'h0000;
		status_word[ST_SRC_LO +: 2] = src_ff; // [R6]
		status_word[ST_WD] = wd_ff;
		status_word[ST_XCVR] = xcvr_ff;
		status_word[ST_UV] = uv_ff;
		status_word[ST_SW_LSB +: NUM_SW] = sw_latch_ff;
		status_word[ST_MODE_LSB +: 2] = state_ff;
	end

	assign frm.status_word = status_word;
	assign frm.ready = (state_ff == ST_ACTIVE); // [R21]

	assign wake_irq_n_out = irq_n_ff;
	assign host_reset_out_n_out = reset_n_ff;
	assign regulator_on_out = reg_ff;
	assign transceiver_on_out = xcvr_ff;
	assign termination_on_out = term_ff;
	assign watchdog_on_out = wd_ff;
	assign divider_on_out = div_ff;
	assign switch_unit_on_out = swu_ff;
	assign low_current_out = lowc_ff;
	assign mode_out = state_ff;
endmodule

// ===== src/mode_ctrl_pkg.sv
package mode_ctrl_pkg;

	// clock and counter sizing
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned TMR_W = 20;
	localparam int unsigned NUM_SW = 3;
	localparam int unsigned FRAME_BITS = 16;

	// times in ns, then cycle counts (least times round up, longest round down)
	localparam int unsigned IGN_DEBOUNCE_NS = 40000;
	localparam int unsigned IGN_DEBOUNCE_CYC =
		(IGN_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BUS_WAKE_NS = 30000;
	localparam int unsigned BUS_WAKE_CYC = (BUS_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PREWAKE_NS = 5000;
	localparam int unsigned PREWAKE_CYC = (PREWAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned MONITOR_NS = 10000000;
	localparam int unsigned MONITOR_CYC = MONITOR_NS / CLK_PERIOD_NS;
	localparam int unsigned STARTUP_DELAY_NS = 4000000;
	localparam int unsigned STARTUP_DELAY_CYC =
		(STARTUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// configuration word fields
	localparam int unsigned CFG_SLEEP = 0;
	localparam int unsigned CFG_LIN = 1;
	localparam int unsigned CFG_WDD = 2;
	localparam int unsigned CFG_DIV = 3;
	localparam int unsigned CFG_CSE_LSB = 4;
	localparam int unsigned CFG_CSIE_LSB = 7;
	localparam int unsigned CFG_CSC_LSB = 10;
	localparam logic [15:0] CFG_RESET = 16'h0000;

	// status word fields
	localparam int unsigned ST_SRC_LO = 14;
	localparam int unsigned ST_WD = 13;
	localparam int unsigned ST_XCVR = 12;
	localparam int unsigned ST_UV = 11;
	localparam int unsigned ST_SW_LSB = 8;
	localparam int unsigned ST_MODE_LSB = 0;

	// interrupt source codes
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_SWITCH = 2'h1;
	localparam logic [1:0] SRC_IGN = 2'h2;
	localparam logic [1:0] SRC_BUS = 2'h3;

	typedef enum logic [1:0] {
		ST_ACTIVE = 2'h0,
		ST_SLEEP = 2'h1,
		ST_RAMP = 2'h3,
		ST_HOLD = 2'h2
	} pwr_state_t;

	typedef enum logic [1:0] {
		DT_LOCKED = 2'h0,
		DT_IDLE = 2'h1,
		DT_DOM = 2'h3
	} det_state_t;

endpackage

// ===== src/frame_if.sv
`timescale 1ns/1ps
interface frame_if;
	logic [15:0] rx_word;
	logic [15:0] status_word;
	logic frame_load;
	logic ready;

	modport spi (output rx_word, output frame_load, input status_word, input ready);
	modport core (input rx_word, input frame_load, output status_word, output ready);
endinterface

// ===== src/spi_frame_slave.sv
`timescale 1ns/1ps
module spi_frame_slave (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// spi pins
	input wire logic sel_n_in,
	input wire logic sck_in,
	input wire logic mosi_in,
	output logic miso_out,
	output logic miso_oe_out,
	// frame exchange with the core
	frame_if.spi frm
);
	import mode_ctrl_pkg::*;

	logic [2:0] pin_m_ff, pin_s_ff;
	logic sel_d_ff, sck_d_ff;
	logic active_ff, nxt_active;
	logic [4:0] cnt_ff, nxt_cnt;
	logic [15:0] rx_ff, nxt_rx, tx_ff, nxt_tx;
	logic miso_ff, nxt_miso, oe_ff, nxt_oe, load_ff, nxt_load;
	logic sel_s, sck_s, mosi_s;

	assign sel_s = pin_s_ff[2];
	assign sck_s = pin_s_ff[1];
	assign mosi_s = pin_s_ff[0];

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pin_m_ff <= 3'h4;
			pin_s_ff <= 3'h4;
			sel_d_ff <= 1'b1;
			sck_d_ff <= 1'b0;
		end else begin
			pin_m_ff <= {sel_n_in, sck_in, mosi_in};
			pin_s_ff <= pin_m_ff;
			sel_d_ff <= sel_s;
			sck_d_ff <= sck_s;
		end
	end

	always_comb begin
		nxt_active = active_ff;
		nxt_cnt = cnt_ff;
		nxt_rx = rx_ff;
		nxt_tx = tx_ff;
		nxt_miso = miso_ff;
		nxt_oe = oe_ff;
		nxt_load = 1'b0;
		// frames are refused while the core holds reset low
		if (sel_d_ff && !sel_s && frm.ready) begin // [R21]
			nxt_active = 1'b1;
			nxt_cnt = 5'h00;
			nxt_tx = frm.status_word; // [R24]
			nxt_miso = frm.status_word[15];
			nxt_oe = 1'b1;
		end else if (active_ff) begin
			if (sel_s) begin
				nxt_active = 1'b0;
				nxt_oe = 1'b0;
				nxt_miso = 1'b0;
				nxt_load = (cnt_ff == 5'(FRAME_BITS)); // [R25]
			end else begin
				if (sck_s && !sck_d_ff) begin
					nxt_rx = {rx_ff[14:0], mosi_s}; // [R24]
					if (cnt_ff != 5'h11) begin
						nxt_cnt = cnt_ff + 5'h01;
					end
				end
				if (!sck_s && sck_d_ff) begin
					nxt_tx = {tx_ff[14:0], 1'b0};
					nxt_miso = tx_ff[14];
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			active_ff <= 1'b0;
			cnt_ff <= 5'h00;
			rx_ff <= 16'h0000;
			tx_ff <= 16'h0000;
			miso_ff <= 1'b0;
			oe_ff <= 1'b0;
			load_ff <= 1'b0;
		end else begin
			active_ff <= nxt_active;
			cnt_ff <= nxt_cnt;
			rx_ff <= nxt_rx;
			tx_ff <= nxt_tx;
			miso_ff <= nxt_miso;
			oe_ff <= nxt_oe;
			load_ff <= nxt_load;
		end
	end

	assign miso_out = miso_ff;
	assign miso_oe_out = oe_ff;
	assign frm.rx_word = rx_ff;
	assign frm.frame_load = load_ff;
endmodule

// ===== src/bus_wake_detector.sv
`timescale 1ns/1ps
module bus_wake_detector #(
	parameter int unsigned MONITOR_CYC = mode_ctrl_pkg::MONITOR_CYC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// synchronised bus levels
	input wire logic enable_in,
	input wire logic bus_low_in,
	input wire logic bus_high_in,
	// results
	output logic wake_out,
	output logic receiver_on_out
);
	import mode_ctrl_pkg::*;

	det_state_t state_ff, nxt_state;
	logic [TMR_W-1:0] cnt_ff, nxt_cnt;
	logic wake_ff, nxt_wake;
	logic rcv_ff, nxt_rcv;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_wake = 1'b0;
		if (!enable_in) begin
			nxt_state = DT_LOCKED;
			nxt_cnt = '0;
		end else begin
			case (state_ff)
				DT_LOCKED: begin
					// re-arm only after the bus sat high long enough
					nxt_cnt = bus_high_in ? cnt_ff + 1'b1 : '0;
					if (bus_high_in && cnt_ff >= TMR_W'(PREWAKE_CYC - 1)) begin // [R13]
						nxt_state = DT_IDLE;
						nxt_cnt = '0;
					end
				end
				DT_IDLE: begin
					if (bus_low_in) begin // [R3]
						nxt_state = DT_DOM;
						nxt_cnt = '0;
					end
				end
				DT_DOM: begin
					if (!bus_low_in) begin
						nxt_wake = (cnt_ff >= TMR_W'(BUS_WAKE_CYC)); // [R3]
						nxt_state = DT_IDLE;
						nxt_cnt = '0;
					end else if (cnt_ff >= TMR_W'(MONITOR_CYC - 1)) begin // [R12]
						nxt_state = DT_LOCKED;
						nxt_cnt = '0;
					end else begin
						nxt_cnt = cnt_ff + 1'b1;
					end
				end
				default: begin
					nxt_state = DT_LOCKED;
					nxt_cnt = '0;
				end
			endcase
		end
		// registered so the top output comes straight from a flop
		nxt_rcv = (nxt_state == DT_DOM); // [R12]
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_ff <= DT_LOCKED;
			cnt_ff <= '0;
			wake_ff <= 1'b0;
			rcv_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			wake_ff <= nxt_wake;
			rcv_ff <= nxt_rcv;
		end
	end

	assign wake_out = wake_ff;
	assign receiver_on_out = rcv_ff; // [R12]
endmodule

// ===== bench/host_spi_model.sv
`timescale 1ns/1ps
module host_spi_model (
	// clock
	input wire logic clk_in,
	// spi pins
	input wire logic miso_in,
	input wire logic miso_oe_in,
	output logic sel_n_out,
	output logic sck_out,
	output logic mosi_out
);
	initial begin
		sel_n_out = 1'b1;
		sck_out = 1'b0;
		mosi_out = 1'b0;
	end
	task automatic gap(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// 4 clocks a phase clears the 3-cycle sync delay of the slave
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		sel_n_out = 1'b0;
		gap(4);
		for (int i = 15; i >= 0; i--) begin
			mosi_out = tx[i];
			gap(4);
			sck_out = 1'b1;
			rx[i] = miso_oe_in ? miso_in : 1'bx;
			gap(4);
			sck_out = 1'b0;
		end
		gap(4);
		sel_n_out = 1'b1;
		// released data line must not look like a held bit
		mosi_out = ~mosi_out;
		gap(8);
	endtask
endmodule

// ===== bench/mode_ctrl_chk.sv
`timescale 1ns/1ps
module mode_ctrl_chk #(
	parameter int unsigned STARTUP_DELAY_CYC = mode_ctrl_pkg::STARTUP_DELAY_CYC,
	parameter int unsigned MONITOR_CYC = mode_ctrl_pkg::MONITOR_CYC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// observed pins
	input wire logic spi_select_n_in,
	input wire logic spi_miso_oe_out,
	input wire logic wake_irq_n_out,
	input wire logic host_reset_out_n_out,
	input wire logic regulator_on_out,
	input wire logic transceiver_on_out,
	input wire logic termination_on_out,
	input wire logic watchdog_on_out,
	input wire logic divider_on_out,
	input wire logic switch_unit_on_out,
	input wire logic low_current_out,
	input wire logic [1:0] mode_out
);
	int unsigned hold_cnt_ff;
	int unsigned nxt_hold_cnt;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	always_comb nxt_hold_cnt = (mode_out == 2'h2) ? hold_cnt_ff + 1 : 0;
	always_ff @(posedge clk_in) hold_cnt_ff <= rst_in ? 0 : nxt_hold_cnt;

	rst_hold_a: assert property (disable iff (1'b0)
		rst_in |=> !host_reset_out_n_out && !spi_miso_oe_out) else $error("reset out not low");
	ready_edge_a: assert property ($rose(host_reset_out_n_out) |-> mode_out == 2'h0
		&& $past(hold_cnt_ff) + 2 >= STARTUP_DELAY_CYC) else $error("early release");
	hold_len_a: assert property (hold_cnt_ff <= STARTUP_DELAY_CYC + 1)
		else $error("hold too long");
	hold_reset_a: assert property (mode_out[1] |-> !host_reset_out_n_out && regulator_on_out)
		else $error("reset not held");
	sleep_off_a: assert property (mode_out == 2'h1 && $past(mode_out) == 2'h1 |->
		!(regulator_on_out || transceiver_on_out || watchdog_on_out || divider_on_out
		|| switch_unit_on_out)) else $error("function on in sleep");
	wake_irq_a: assert property ($past(mode_out) == 2'h1 && mode_out == 2'h3
		|-> ##[0:2] !wake_irq_n_out) else $error("no irq on wake");
	lin_off_a: assert property (mode_out[1] |-> !transceiver_on_out && termination_on_out)
		else $error("bad enables in startup");
	sleep_cause_a: assert property ($rose(mode_out == 2'h1) |-> $past(spi_select_n_in)
		&& (!$past(spi_select_n_in, 5) || !$past(spi_select_n_in, 6))) else $error("bad sleep");
	irq_release_a: assert property ($rose(wake_irq_n_out) |-> $past(spi_select_n_in)
		&& (!$past(spi_select_n_in, 5) || !$past(spi_select_n_in, 6))) else $error("bad release");
	spi_quiet_a: assert property (!host_reset_out_n_out |-> !spi_miso_oe_out)
		else $error("spi answers in reset");
	select_wakes_a: assert property (!spi_select_n_in [*5] |-> !low_current_out)
		else $error("low current while selected");
endmodule

bind sleep_wake_mode_controller mode_ctrl_chk #(
	.STARTUP_DELAY_CYC(STARTUP_DELAY_CYC),
	.MONITOR_CYC(MONITOR_CYC)
) u_chk (
	.clk_in(clk_in),
	.rst_in(rst_in),
	.spi_select_n_in(spi_select_n_in),
	.spi_miso_oe_out(spi_miso_oe_out),
	.wake_irq_n_out(wake_irq_n_out),
	.host_reset_out_n_out(host_reset_out_n_out),
	.regulator_on_out(regulator_on_out),
	.transceiver_on_out(transceiver_on_out),
	.termination_on_out(termination_on_out),
	.watchdog_on_out(watchdog_on_out),
	.divider_on_out(divider_on_out),
	.switch_unit_on_out(switch_unit_on_out),
	.low_current_out(low_current_out),
	.mode_out(mode_out)
);

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import mode_ctrl_pkg::*;
	typedef struct packed {logic [15:0] cfg; logic [3:0] exp;} row_t;
	logic clk_in = 1'b0, rst_in = 1'b1, vcc_valid_in = 1'b0, strap = 1'b0;
	logic sup_low = 1'b0, sup_ok = 1'b1, bus_low = 1'b0, bus_high = 1'b1, ign = 1'b0;
	logic [NUM_SW-1:0] pulse = '0, sw = '0;
	logic sel_n, sck, mosi, miso, miso_oe, irq_n, res_n, reg_on, xcvr_on, term_on;
	logic wd_on, div_on, swu_on, rcv_on, lowc;
	logic [1:0] mode, prev;
	logic [15:0] st;
	int fails = 0, cmp_count = 0;
	// expected {transceiver, watchdog, divider, low current}
	row_t rows [4] = '{'{16'h0002, 4'hC}, '{16'h000C, 4'h2}, '{16'h0004, 4'h1},
		'{16'h0006, 4'h8}};

	sleep_wake_mode_controller #(.STARTUP_DELAY_CYC(20), .MONITOR_CYC(600)) u_dut (
		.clk_in(clk_in), .rst_in(rst_in),
		.supply_low_in(sup_low), .supply_ok_in(sup_ok),
		.supply_min_in(1'b0), .vcc_valid_in(vcc_valid_in),
		.bus_low_in(bus_low), .bus_high_in(bus_high), .ignition_input_in(ign),
		.pulse_control_input_in(pulse), .switch_state_in(sw),
		.divider_strap_in(strap),
		.spi_select_n_in(sel_n), .spi_sck_in(sck), .spi_mosi_in(mosi),
		.spi_miso_out(miso), .spi_miso_oe_out(miso_oe),
		.wake_irq_n_out(irq_n), .host_reset_out_n_out(res_n),
		.regulator_on_out(reg_on), .transceiver_on_out(xcvr_on),
		.termination_on_out(term_on), .watchdog_on_out(wd_on),
		.divider_on_out(div_on), .switch_unit_on_out(swu_on),
		.bus_receiver_on_out(rcv_on), .low_current_out(lowc), .mode_out(mode)
	);
	host_spi_model u_host (
		.clk_in(clk_in), .miso_in(miso), .miso_oe_in(miso_oe),
		.sel_n_out(sel_n), .sck_out(sck), .mosi_out(mosi)
	);

	initial forever #50 clk_in = ~clk_in;
	// regulator output becomes valid at the falling clock edge after it is switched on
	always @(negedge clk_in) vcc_valid_in <= reg_on;

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic wait_mode(input logic [1:0] m);
		int n = 0;
		while (mode !== m && n < 2000) begin
			cyc(1);
			n++;
		end
		if (mode !== m) begin
			fails++;
			$display("Error mode wait expected %h seen %h", m, mode);
			final_report();
		end
	endtask
	task automatic bus_dom(input int n);
		bus_low = 1'b1;
		bus_high = 1'b0;
		cyc(n);
		bus_low = 1'b0;
		bus_high = 1'b1;
	endtask
	task automatic sw_scan(input logic s);
		sw[0] = s;
		pulse[0] = 1'b1;
		cyc(5);
		pulse[0] = 1'b0;
		cyc(6);
	endtask

	initial begin
		cyc(8);
		chk("reset out", 16'h0, 16'(res_n));
		rst_in = 1'b0;
		wait_mode(2'h0);
		chk("power-up enables", 16'h3, 16'({reg_on, wd_on}));
		$display("test power-up done");
		prev = 2'b01;
		foreach (rows[i]) begin
			u_host.xfer(rows[i].cfg, st);
			chk("status bits", 16'(prev), 16'({st[ST_XCVR], st[ST_WD]}));
			chk("source", 16'(SRC_NONE), 16'(st[15:14]));
			cyc(10);
			chk("enables", 16'(rows[i].exp), 16'({xcvr_on, wd_on, div_on, lowc}));
			prev = rows[i].exp[3:2];
		end
		$display("test config rows done");
		u_host.xfer(16'h0094, st);
		sw_scan(1'b1);
		chk("switch irq", 16'h0, 16'(irq_n));
		u_host.xfer(16'h0014, st);
		chk("switch source", 16'(SRC_SWITCH), 16'(st[15:14]));
		chk("irq released", 16'h1, 16'(irq_n));
		sw_scan(1'b0);
		chk("masked switch", 16'h1, 16'(irq_n));
		$display("test switch done");
		u_host.xfer(16'h0416, st);
		sup_low = 1'b1;
		sup_ok = 1'b0;
		cyc(6);
		chk("uv irq and lin", 16'h0, 16'({irq_n, xcvr_on, swu_on}));
		sup_low = 1'b0;
		sup_ok = 1'b1;
		cyc(6);
		chk("lin resumes", 16'h3, 16'({xcvr_on, swu_on}));
		u_host.xfer(16'h0004, st);
		ign = 1'b1;
		cyc(450);
		chk("ign irq low-power", 16'h0, 16'({irq_n, mode}));
		u_host.xfer(16'h0004, st);
		chk("ign source", 16'(SRC_IGN), 16'(st[15:14]));
		ign = 1'b0;
		cyc(450);
		bus_dom(350);
		cyc(5);
		chk("bus irq low-power", 16'h0, 16'({irq_n, mode}));
		u_host.xfer(16'h0004, st);
		chk("bus source low-power", 16'(SRC_BUS), 16'(st[15:14]));
		$display("test undervoltage and low-power wake done");
		u_host.xfer(16'h0005, st);
		chk("sleep entry", 16'h1, 16'({reg_on, mode}));
		sup_low = 1'b1;
		sup_ok = 1'b0;
		ign = 1'b1;
		cyc(200);
		ign = 1'b0;
		sup_low = 1'b0;
		sup_ok = 1'b1;
		bus_dom(100);
		cyc(460);
		chk("short wakes", 16'h1, 16'(mode));
		bus_low = 1'b1;
		bus_high = 1'b0;
		cyc(10);
		chk("receiver open", 16'h1, 16'(rcv_on));
		cyc(640);
		chk("monitor window", 16'h0, 16'(rcv_on));
		bus_low = 1'b0;
		bus_high = 1'b1;
		cyc(10);
		bus_dom(350);
		cyc(10);
		chk("no rearm", 16'h1, 16'(mode));
		cyc(60);
		bus_dom(350);
		cyc(4);
		chk("bus wake pins", 16'h3, 16'({irq_n, xcvr_on, term_on, reg_on}));
		wait_mode(2'h0);
		chk("reset released", 16'h1, 16'(res_n));
		u_host.xfer(16'h0004, st);
		chk("bus source", 16'(SRC_BUS), 16'(st[15:14]));
		chk("irq after read", 16'h1, 16'(irq_n));
		u_host.xfer(16'h0005, st);
		strap = 1'b1;
		ign = 1'b1;
		cyc(450);
		chk("ign wake irq", 16'h0, 16'(irq_n));
		wait_mode(2'h0);
		chk("strap watchdog off", 16'h0, 16'(wd_on));
		u_host.xfer(16'h0004, st);
		chk("ign wake source", 16'(SRC_IGN), 16'(st[15:14]));
		$display("test sleep wake done");
		final_report();
	end
endmodule
